// ==== src/fcp_bus_cycle.v ====
// Purpose: One asynchronous flash bus cycle (read or write) per request
// Assumes: Flash data is stable by the end of the read strobe window
// Notes: Address and data are held across setup, strobe and hold phases
`timescale 1ns/1ps
`include "fcp_defs.vh"

module fcp_bus_cycle
(
    // Clock and reset
    input wire clk_in,
    input wire rst_n_in,
    // Request side
    input wire req_in,
    input wire wr_in,
    input wire [19:0] addr_in,
    input wire [15:0] wdata_in,
    output wire busy_out,
    output reg done_out,
    output reg [15:0] rdata_out,
    // Flash pins
    output reg [19:0] flash_addr_out,
    output reg [15:0] flash_dq_out,
    output reg flash_dq_oe_out,
    input wire [15:0] flash_dq_in,
    output reg flash_ce_n_out,
    output reg flash_we_n_out,
    output reg flash_oe_n_out
);

localparam ST_IDLE = 2'd0;
localparam ST_SETUP = 2'd1;
localparam ST_STROBE = 2'd2;
localparam ST_HOLD = 2'd3;

reg [1:0] state_q;
reg [3:0] cnt_q;
reg wr_q;
reg [15:0] dq_s1_q;
reg [15:0] dq_s2_q;

assign busy_out = (state_q != ST_IDLE);

// Data pins pass two flops since the flash answers asynchronously
always @(posedge clk_in or negedge rst_n_in)
begin
    if (!rst_n_in)
    begin
        dq_s1_q <= 16'h0000;
        dq_s2_q <= 16'h0000;
    end
    else
    begin
        dq_s1_q <= flash_dq_in;
        dq_s2_q <= dq_s1_q;
    end
end

// Strobe sequencer: address settles before the strobe falls, so the
// device latches address on the falling edge and data on the rising one
always @(posedge clk_in or negedge rst_n_in)
begin
    if (!rst_n_in)
    begin
        state_q <= ST_IDLE;
        cnt_q <= 4'h0;
        wr_q <= 1'b0;
        done_out <= 1'b0;
        rdata_out <= 16'h0000;
        flash_addr_out <= 20'h00000;
        flash_dq_out <= 16'h0000;
        flash_dq_oe_out <= 1'b0;
        flash_ce_n_out <= 1'b1;
        flash_we_n_out <= 1'b1;
        flash_oe_n_out <= 1'b1;
    end
    else
    begin
        done_out <= 1'b0;
        case (state_q)
            ST_IDLE:
            begin
                if (req_in)
                begin
                    wr_q <= wr_in;
                    flash_addr_out <= addr_in;
                    flash_dq_out <= wdata_in;
                    flash_dq_oe_out <= wr_in;
                    flash_ce_n_out <= 1'b0;
                    cnt_q <= `FCP_T_SETUP;
                    state_q <= ST_SETUP;
                end
            end
            ST_SETUP:
            begin
                if (cnt_q == 4'h0)
                begin
                    flash_we_n_out <= ~wr_q;
                    flash_oe_n_out <= wr_q;
                    cnt_q <= wr_q ? `FCP_T_STROBE : `FCP_T_READ;
                    state_q <= ST_STROBE;
                end
                else
                    cnt_q <= cnt_q - 4'h1;
            end
            ST_STROBE:
            begin
                if (cnt_q == 4'h0)
                begin
                    // Sample on the last strobe cycle; sync delay is covered
                    if (!wr_q)
                        rdata_out <= dq_s2_q;
                    flash_we_n_out <= 1'b1;
                    flash_oe_n_out <= 1'b1;
                    cnt_q <= `FCP_T_HOLD;
                    state_q <= ST_HOLD;
                end
                else
                    cnt_q <= cnt_q - 4'h1;
            end
            ST_HOLD:
            begin
                if (cnt_q == 4'h0)
                begin
                    flash_ce_n_out <= 1'b1;
                    flash_dq_oe_out <= 1'b0;
                    done_out <= 1'b1;
                    state_q <= ST_IDLE;
                end
                else
                    cnt_q <= cnt_q - 4'h1;
            end
            default:
                state_q <= ST_IDLE;
        endcase
    end
end

endmodule // fcp_bus_cycle

// ==== src/fcp_defs.vh ====
// Purpose: Constants for the flash command and status-poll controller
// Assumes: Word-mode flash, 20-bit word address, 16-bit data bus
// Notes: Bus timing counts are in cycles of the 100 MHz clock
`ifndef FCP_DEFS_VH
`define FCP_DEFS_VH

// Unlock addresses and data (word mode)
`define FCP_ADDR_UNLOCK1 20'h00555
`define FCP_ADDR_UNLOCK2 20'h002aa
`define FCP_DATA_UNLOCK1 16'h00aa
`define FCP_DATA_UNLOCK2 16'h0055

// Command data values
`define FCP_CMD_RESET 16'h00f0
`define FCP_CMD_AUTOSEL 16'h0090
`define FCP_CMD_PROGRAM 16'h00a0
`define FCP_CMD_ERASE_SETUP 16'h0080
`define FCP_CMD_CHIP_ERASE 16'h0010
`define FCP_CMD_SECTOR_ERASE 16'h0030
`define FCP_CMD_SUSPEND 16'h00b0
`define FCP_CMD_RESUME 16'h0030
`define FCP_CMD_BYPASS 16'h0020
`define FCP_CMD_BYPASS_RST1 16'h0090
`define FCP_CMD_BYPASS_RST2 16'h0000

// Status bit positions
`define FCP_BIT_POLL 7
`define FCP_BIT_TIMEOUT 5

// Sector address field
`define FCP_SECT_HI 19
`define FCP_SECT_LO 12

// User operation codes
`define FCP_OP_READ 4'h0
`define FCP_OP_PROGRAM 4'h1
`define FCP_OP_CHIP_ERASE 4'h2
`define FCP_OP_SECT_ERASE 4'h3
`define FCP_OP_SUSPEND 4'h4
`define FCP_OP_RESUME 4'h5
`define FCP_OP_RESET 4'h6
`define FCP_OP_AUTOSEL 4'h7
`define FCP_OP_BYPASS 4'h8
`define FCP_OP_BYPASS_PROG 4'h9
`define FCP_OP_BYPASS_RST 4'ha

// Bus cycle timing, in clock cycles
`define FCP_T_SETUP 4'h2
`define FCP_T_STROBE 4'h5
`define FCP_T_READ 4'h9
`define FCP_T_HOLD 4'h2

// Poll attempts before giving up
`define FCP_POLL_LIMIT 24'hffffff

`endif

// ==== src/fcp_flash_ctrl.v ====
// Overview of operation
// - Suspend is one write of B0 anywhere.
// - Command cycles are writes, except data reads.
// - Reset command leaves autoselect or timeout failure.
// - Autoselect fourth cycle is a read.
// - Enter bypass before bypass program.
// - Bypass reset needed to leave bypass.
// - Poll program status at program address.
// - Poll erase status inside an erasing sector.
// - Valid data only from reads after true.
// - Re-read poll bit after timeout bit set.
//
// Purpose: Host-side controller issuing flash command sequences and polling
// Assumes: Word-mode device; user holds op, addr, data while start pulses
// Notes: One operation at a time; done pulses once with ok or fail
`timescale 1ns/1ps
`include "fcp_defs.vh"

module fcp_flash_ctrl
(
    // Clock and reset
    input wire clk_in,
    input wire rst_n_in,
    // User command port
    input wire start_in,
    input wire [3:0] op_in,
    input wire [19:0] addr_in,
    input wire [15:0] data_in,
    output wire ready_out,
    output reg done_out,
    output reg fail_out,
    output reg [15:0] rdata_out,
    output reg bypass_out,
    output reg suspended_out,
    // Flash pins
    output wire [19:0] flash_addr_out,
    output wire [15:0] flash_dq_out,
    output wire flash_dq_oe_out,
    input wire [15:0] flash_dq_in,
    output wire flash_ce_n_out,
    output wire flash_we_n_out,
    output wire flash_oe_n_out
);

localparam ST_IDLE = 3'd0;
localparam ST_ISSUE = 3'd1;
localparam ST_WAIT = 3'd2;
localparam ST_POLL = 3'd3;
localparam ST_POLL_WAIT = 3'd4;
localparam ST_RECHECK = 3'd5;
localparam ST_FINAL = 3'd6;
localparam ST_DONE = 3'd7;

reg [2:0] state_q;
reg [3:0] op_q;
reg [19:0] addr_q;
reg [15:0] data_q;
reg [2:0] step_q;
reg [23:0] poll_cnt_q;
reg fail_q;
reg cyc_wr_q;
reg cyc_req;
reg cyc_wr;
reg [19:0] cyc_addr;
reg [15:0] cyc_wdata;
wire cyc_busy;
wire cyc_done;
wire [15:0] cyc_rdata;
wire [2:0] last_step;
wire poll_true;

// Number of bus cycles in each command sequence, minus one
function [2:0] seq_len;
    input [3:0] op;
    begin
        case (op)
            `FCP_OP_READ: seq_len = 3'd0;
            `FCP_OP_PROGRAM: seq_len = 3'd3;
            `FCP_OP_CHIP_ERASE: seq_len = 3'd5;
            `FCP_OP_SECT_ERASE: seq_len = 3'd5;
            `FCP_OP_SUSPEND: seq_len = 3'd0;
            `FCP_OP_RESUME: seq_len = 3'd0;
            `FCP_OP_RESET: seq_len = 3'd0;
            `FCP_OP_AUTOSEL: seq_len = 3'd3;
            `FCP_OP_BYPASS: seq_len = 3'd2;
            `FCP_OP_BYPASS_PROG: seq_len = 3'd1;
            `FCP_OP_BYPASS_RST: seq_len = 3'd1;
            default: seq_len = 3'd0;
        endcase
    end
endfunction

// True when an operation starts an embedded algorithm worth polling
function is_embedded;
    input [3:0] op;
    begin
        is_embedded = (op == `FCP_OP_PROGRAM) || (op == `FCP_OP_BYPASS_PROG) ||
            (op == `FCP_OP_CHIP_ERASE) || (op == `FCP_OP_SECT_ERASE);
    end
endfunction

assign last_step = seq_len(op_q);
assign ready_out = (state_q == ST_IDLE);

// Expected true value: programmed bit 7, or one for erase
assign poll_true = ((op_q == `FCP_OP_PROGRAM) || (op_q == `FCP_OP_BYPASS_PROG)) ?
    data_q[`FCP_BIT_POLL] : 1'b1;

// Bus cycle for the current step of the sequence
always @*
begin
    cyc_wr = 1'b1;
    cyc_addr = `FCP_ADDR_UNLOCK1;
    cyc_wdata = `FCP_DATA_UNLOCK1;
    cyc_req = (state_q == ST_ISSUE) || (state_q == ST_POLL) ||
        (((state_q == ST_RECHECK) || (state_q == ST_FINAL)) && !cyc_done);
    if (state_q != ST_ISSUE)
    begin
        // Status reads go to the program address or the erasing sector
        cyc_wr = 1'b0;
        cyc_addr = addr_q;
        cyc_wdata = 16'h0000;
    end
    else
    begin
        case (op_q)
            `FCP_OP_READ:
            begin
                cyc_wr = 1'b0;
                cyc_addr = addr_q;
            end
            `FCP_OP_SUSPEND:
                cyc_wdata = `FCP_CMD_SUSPEND;
            `FCP_OP_RESUME:
                cyc_wdata = `FCP_CMD_RESUME;
            `FCP_OP_RESET:
                cyc_wdata = `FCP_CMD_RESET;
            `FCP_OP_BYPASS_PROG:
            begin
                // Shortened program: only legal once bypass is entered
                cyc_addr = (step_q == 3'd0) ? `FCP_ADDR_UNLOCK1 : addr_q;
                cyc_wdata = (step_q == 3'd0) ? `FCP_CMD_PROGRAM : data_q;
            end
            `FCP_OP_BYPASS_RST:
                cyc_wdata = (step_q == 3'd0) ? `FCP_CMD_BYPASS_RST1 :
                    `FCP_CMD_BYPASS_RST2;
            default:
            begin
                case (step_q)
                    3'd0:
                        cyc_wdata = `FCP_DATA_UNLOCK1;
                    3'd1, 3'd4:
                    begin
                        cyc_addr = `FCP_ADDR_UNLOCK2;
                        cyc_wdata = `FCP_DATA_UNLOCK2;
                    end
                    3'd2:
                        cyc_wdata = (op_q == `FCP_OP_PROGRAM) ? `FCP_CMD_PROGRAM :
                            (op_q == `FCP_OP_AUTOSEL) ? `FCP_CMD_AUTOSEL :
                            (op_q == `FCP_OP_BYPASS) ? `FCP_CMD_BYPASS :
                            `FCP_CMD_ERASE_SETUP;
                    3'd3:
                    begin
                        if (op_q == `FCP_OP_PROGRAM)
                        begin
                            cyc_addr = addr_q;
                            cyc_wdata = data_q;
                        end
                        else if (op_q == `FCP_OP_AUTOSEL)
                        begin
                            // Fourth cycle reads ID or protection (00h/01h)
                            cyc_wr = 1'b0;
                            cyc_addr = addr_q;
                        end
                    end
                    3'd5:
                    begin
                        if (op_q == `FCP_OP_CHIP_ERASE)
                            cyc_wdata = `FCP_CMD_CHIP_ERASE;
                        else
                        begin
                            // Sector picked by bits 19..12, low bits don't care
                            cyc_addr = {addr_q[`FCP_SECT_HI:`FCP_SECT_LO], 12'h000};
                            cyc_wdata = `FCP_CMD_SECTOR_ERASE;
                        end
                    end
                    default:
                    begin
                        cyc_addr = `FCP_ADDR_UNLOCK1;
                        cyc_wdata = `FCP_CMD_RESET;
                    end
                endcase
            end
        endcase
    end
end

// Sequencer: issue cycles, then for embedded ops poll bit 7 until true or timeout
always @(posedge clk_in or negedge rst_n_in)
begin
    if (!rst_n_in)
    begin
        state_q <= ST_IDLE;
        op_q <= `FCP_OP_READ;
        addr_q <= 20'h00000;
        data_q <= 16'h0000;
        step_q <= 3'd0;
        poll_cnt_q <= 24'h000000;
        fail_q <= 1'b0;
        done_out <= 1'b0;
        fail_out <= 1'b0;
        rdata_out <= 16'h0000;
        bypass_out <= 1'b0;
        suspended_out <= 1'b0;
    end
    else
    begin
        done_out <= 1'b0;
        case (state_q)
            ST_IDLE:
            begin
                if (start_in)
                begin
                    op_q <= op_in;
                    addr_q <= addr_in;
                    data_q <= data_in;
                    step_q <= 3'd0;
                    poll_cnt_q <= 24'h000000;
                    fail_q <= 1'b0;
                    state_q <= ST_ISSUE;
                end
            end
            ST_ISSUE:
                state_q <= ST_WAIT;
            ST_WAIT:
            begin
                if (cyc_done)
                begin
                    if (step_q != last_step)
                    begin
                        step_q <= step_q + 3'd1;
                        state_q <= ST_ISSUE;
                    end
                    else
                    begin
                        if (!cyc_wr_q)
                            rdata_out <= cyc_rdata;
                        // Polling starts only after the last strobe has risen
                        state_q <= is_embedded(op_q) ? ST_POLL : ST_DONE;
                    end
                end
            end
            ST_POLL:
                state_q <= ST_POLL_WAIT;
            ST_POLL_WAIT:
            begin
                if (cyc_done)
                begin
                    poll_cnt_q <= poll_cnt_q + 24'h000001;
                    if (cyc_rdata[`FCP_BIT_POLL] == poll_true)
                        state_q <= ST_FINAL;
                    else if (cyc_rdata[`FCP_BIT_TIMEOUT])
                        state_q <= ST_RECHECK;
                    else if (poll_cnt_q == `FCP_POLL_LIMIT)
                    begin
                        fail_q <= 1'b1;
                        state_q <= ST_DONE;
                    end
                    else
                        state_q <= ST_POLL;
                end
            end
            ST_RECHECK:
            begin
                // Bit 7 may flip together with the timeout bit
                if (cyc_done)
                begin
                    if (cyc_rdata[`FCP_BIT_POLL] == poll_true)
                        state_q <= ST_FINAL;
                    else
                    begin
                        fail_q <= 1'b1;
                        op_q <= `FCP_OP_RESET;
                        step_q <= 3'd0;
                        state_q <= ST_ISSUE;
                    end
                end
            end
            ST_FINAL:
            begin
                // Fresh read after the true value gives trusted data
                if (cyc_done)
                begin
                    rdata_out <= cyc_rdata;
                    state_q <= ST_DONE;
                end
            end
            ST_DONE:
            begin
                done_out <= 1'b1;
                fail_out <= fail_q;
                if (op_q == `FCP_OP_BYPASS)
                    bypass_out <= 1'b1;
                if (op_q == `FCP_OP_BYPASS_RST)
                    bypass_out <= 1'b0;
                if (op_q == `FCP_OP_SUSPEND)
                    suspended_out <= 1'b1;
                if (op_q == `FCP_OP_RESUME)
                    suspended_out <= 1'b0;
                state_q <= ST_IDLE;
            end
            default:
                state_q <= ST_IDLE;
        endcase
    end
end

// Remembers whether the last issued cycle was a write
always @(posedge clk_in or negedge rst_n_in)
begin
    if (!rst_n_in)
        cyc_wr_q <= 1'b1;
    else if (cyc_req)
        cyc_wr_q <= cyc_wr;
end

// ST_RECHECK and ST_FINAL request once on entry and wait on done
fcp_bus_cycle u_bus
(
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .req_in(cyc_req && !cyc_busy),
    .wr_in(cyc_wr),
    .addr_in(cyc_addr),
    .wdata_in(cyc_wdata),
    .busy_out(cyc_busy),
    .done_out(cyc_done),
    .rdata_out(cyc_rdata),
    .flash_addr_out(flash_addr_out),
    .flash_dq_out(flash_dq_out),
    .flash_dq_oe_out(flash_dq_oe_out),
    .flash_dq_in(flash_dq_in),
    .flash_ce_n_out(flash_ce_n_out),
    .flash_we_n_out(flash_we_n_out),
    .flash_oe_n_out(flash_oe_n_out)
);

endmodule // fcp_flash_ctrl

// ==== tb/fcp_flash_ctrl_sva.sv ====
// Purpose: Port-level checks on the flash command and poll controller
// Assumes: One 100 MHz clock, asynchronous active-low reset
// Notes: Write strobe width is checked with some slack
`timescale 1ns/1ps
module fcp_flash_ctrl_sva
(
    // Clock and reset
    input wire clk_in,
    input wire rst_n_in,
    // User command port
    input wire start_in,
    input wire ready_out,
    input wire done_out,
    input wire bypass_out,
    input wire suspended_out,
    // Flash pins
    input wire [19:0] flash_addr_out,
    input wire [15:0] flash_dq_out,
    input wire flash_dq_oe_out,
    input wire flash_ce_n_out,
    input wire flash_we_n_out,
    input wire flash_oe_n_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // A write strobe is a low pulse of bounded width
    sequence we_pulse;
        (!flash_we_n_out)[*4] ##[1:6] flash_we_n_out;
    endsequence
    chk_we_width: assert property ($fell(flash_we_n_out) |-> we_pulse)
        else $error("write strobe width out of range");
    chk_we_in_ce: assert property (!flash_we_n_out |-> !flash_ce_n_out)
        else $error("write strobe without chip select");
    chk_wr_drives: assert property (!flash_we_n_out |-> flash_dq_oe_out)
        else $error("write strobe with data bus released");
    chk_rd_release: assert property (!flash_oe_n_out |-> !flash_dq_oe_out && flash_we_n_out)
        else $error("read strobe while host drives");
    chk_wr_stable: assert property (!flash_we_n_out && $past(!flash_we_n_out)
        |-> $stable(flash_addr_out) && $stable(flash_dq_out))
        else $error("address or data moved under write strobe");
    chk_data_hold: assert property ($rose(flash_we_n_out)
        |-> $stable(flash_dq_out) && flash_dq_oe_out)
        else $error("data not held at strobe rise");
    chk_done_pulse: assert property (done_out |=> !done_out)
        else $error("done longer than one cycle");
    chk_done_ready: assert property (done_out |=> ready_out)
        else $error("not ready after done");
    chk_take_busy: assert property (start_in && ready_out |=> !ready_out)
        else $error("request not taken");
    chk_idle_bus: assert property (ready_out |-> flash_ce_n_out && flash_we_n_out && flash_oe_n_out)
        else $error("bus active while idle");
    chk_mode_hold: assert property (ready_out && !start_in
        |=> $stable(bypass_out) && $stable(suspended_out))
        else $error("mode flag changed while idle");
endmodule // fcp_flash_ctrl_sva

bind fcp_flash_ctrl fcp_flash_ctrl_sva chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .start_in(start_in), .ready_out(ready_out), .done_out(done_out),
    .bypass_out(bypass_out), .suspended_out(suspended_out),
    .flash_addr_out(flash_addr_out), .flash_dq_out(flash_dq_out),
    .flash_dq_oe_out(flash_dq_oe_out), .flash_ce_n_out(flash_ce_n_out),
    .flash_we_n_out(flash_we_n_out), .flash_oe_n_out(flash_oe_n_out));

// ==== tb/fcp_flash_model.sv ====
// Purpose: Behavioural flash device with command decode and status polling
// Assumes: Busy time is counted in status reads, not in wall time
// Notes: Released data lines show the inverse of the last driven word
`timescale 1ns/1ps
module fcp_flash_model #(
    parameter [7:0] PROT_SECT = 8'h05,
    parameter integer BUSY_RD = 3,
    parameter [15:0] ID_WORD = 16'h00c3 // Arbitrary identity word
)
(
    // Flash pins seen from the device
    input wire [19:0] addr_in,
    input wire [15:0] dq_in,
    input wire ce_n_in,
    input wire we_n_in,
    input wire oe_n_in,
    output wire [15:0] dq_out
);
    reg [15:0] mem [0:1023];
    reg [15:0] last = 16'h0000, pd = 16'h0000, rv;
    reg [19:0] al = 20'h00000, pa = 20'h00000;
    reg [7:0] es = 8'h00;
    reg [2:0] st = 3'h0;
    reg asel = 0, byp = 0, susp = 0, kind = 0, tog = 0, t5 = 0, chip = 0;
    integer bcnt = 0, sv = 0, i;
    function [9:0] ix(input [19:0] a);
        ix = {a[19:12], a[1:0]};
    endfunction
    initial
        for (i = 0; i < 1024; i = i + 1)
            mem[i] = 16'hffff;
    // Status while busy, else mode-dependent data
    always @*
    begin
        if (bcnt != 0)
            rv = {8'h00, kind ? 1'b0 : ~pd[7], tog, t5, 5'h00};
        else if (susp && addr_in[19:12] == es)
            rv = 16'h0080;
        else if (asel)
            rv = addr_in[1:0] == 2'b10 ? {15'h0, addr_in[19:12] == PROT_SECT} : ID_WORD;
        else
            rv = mem[ix(addr_in)];
    end
    assign dq_out = (!ce_n_in && !oe_n_in) ? rv : ~last;
    // Address latches on the later falling strobe
    always @(negedge we_n_in or negedge ce_n_in)
        if (!we_n_in && !ce_n_in)
            al = addr_in;
    // Data latches on the earlier rising strobe
    always @(posedge we_n_in or posedge ce_n_in)
        if (we_n_in != ce_n_in)
            cmd(dq_in);
    // End of a read cycle advances the embedded operation
    always @(posedge oe_n_in)
        if (!ce_n_in)
        begin
            last = rv;
            tog = ~tog;
            if (bcnt != 0 && !t5)
            begin
                bcnt = bcnt - 1;
                if (bcnt == 0 && kind)
                    for (i = 0; i < 1024; i = i + 1)
                        if ((chip || i[9:2] == es) && i[9:2] != PROT_SECT)
                            mem[i] = 16'hffff;
                if (bcnt == 0 && !kind && pa[19:12] != PROT_SECT)
                    mem[ix(pa)] = pd;
            end
        end
    task cmd(input [15:0] d);
        reg [10:0] u;
    begin
        u = al[10:0];
        if (d[7:0] == 8'hf0 && !byp)
        begin
            st = 0; asel = 0; t5 = 0; bcnt = 0;
        end
        else if (d[7:0] == 8'hb0 && kind && bcnt != 0)
        begin
            susp = 1; sv = bcnt; bcnt = 0;
        end
        else if (d[7:0] == 8'h30 && susp && st == 0)
        begin
            susp = 0; kind = 1; bcnt = sv;
        end
        else if (bcnt == 0)
            case (st)
                0: st = byp && d[7:0] == 8'ha0 ? 3 : byp && d[7:0] == 8'h90 ? 6 :
                    (u == 11'h555 && d[7:0] == 8'haa) ? 1 : 0;
                1: st = (u == 11'h2aa && d[7:0] == 8'h55) ? 2 : 0;
                2:
                begin
                    st = 0;
                    if (u == 11'h555)
                        case (d[7:0])
                            8'ha0: st = 3;
                            8'h80: st = 4;
                            8'h90: asel = 1;
                            8'h20: byp = 1;
                            default: st = 0;
                        endcase
                end
                3:
                begin
                    st = 0; pa = al; pd = d; kind = 0; bcnt = BUSY_RD;
                    t5 = pa[19:12] != PROT_SECT && |(pd & ~mem[ix(pa)]);
                end
                4: st = (u == 11'h555 && d[7:0] == 8'haa) ? 5 : 0;
                5: st = (u == 11'h2aa && d[7:0] == 8'h55) ? 7 : 0;
                6:
                begin
                    st = 0;
                    if (d[7:0] == 8'h00)
                        byp = 0;
                end
                7:
                begin
                    st = 0; kind = 1; chip = d[7:0] == 8'h10; es = al[19:12];
                    if (d[7:0] == 8'h10 || d[7:0] == 8'h30)
                        bcnt = BUSY_RD;
                end
            endcase
    end
    endtask
endmodule // fcp_flash_model

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench for the flash command and poll controller
// Assumes: Flash model answers status for a few reads per operation
// Notes: Inputs change on the falling clock edge only
`timescale 1ns/1ps
`include "fcp_defs.vh"
module testbench;
    reg clk_in = 1'b0;
    reg rst_n_in = 1'b0;
    reg start_in = 1'b0;
    reg [3:0] op_in = 4'h0;
    reg [19:0] addr_in = 20'h00000;
    reg [15:0] data_in = 16'h0000;
    wire ready_out, done_out, fail_out, bypass_out, suspended_out, dq_oe, ce_n, we_n, oe_n;
    wire [15:0] rdata_out, dq_out, dev_dq, dq_bus;
    wire [19:0] fa;
    integer mismatches = 0;
    integer n_checks = 0;
    integer cycles = 0;
    // Shared data wire: host drives when enabled, else the device
    assign dq_bus = dq_oe ? dq_out : dev_dq;
    always #5 clk_in = ~clk_in;
    fcp_flash_ctrl uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .start_in(start_in),
        .op_in(op_in), .addr_in(addr_in), .data_in(data_in), .ready_out(ready_out),
        .done_out(done_out), .fail_out(fail_out), .rdata_out(rdata_out),
        .bypass_out(bypass_out), .suspended_out(suspended_out), .flash_addr_out(fa),
        .flash_dq_out(dq_out), .flash_dq_oe_out(dq_oe), .flash_dq_in(dq_bus),
        .flash_ce_n_out(ce_n), .flash_we_n_out(we_n), .flash_oe_n_out(oe_n));
    fcp_flash_model dev (.addr_in(fa), .dq_in(dq_bus), .ce_n_in(ce_n), .we_n_in(we_n),
        .oe_n_in(oe_n), .dq_out(dev_dq));
    task finish_test;
    begin
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
    endtask
    task check(input [15:0] got, input [15:0] exp);
    begin
        n_checks = n_checks + 1;
        if (got !== exp)
        begin
            mismatches = mismatches + 1;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    // One user request, then wait for its done pulse
    task run_op(input [3:0] code, input [19:0] a, input [15:0] d);
    begin
        @(negedge clk_in);
        op_in = code;
        addr_in = a;
        data_in = d;
        start_in = 1'b1;
        @(negedge clk_in);
        start_in = 1'b0;
        while (done_out !== 1'b1)
            @(negedge clk_in);
    end
    endtask
    task op_chk(input [3:0] code, input [19:0] a, input [15:0] d, input [15:0] exp);
    begin
        run_op(code, a, d);
        check(rdata_out, exp);
    end
    endtask
    // Hang guard, well above the expected run length
    always @(posedge clk_in)
    begin
        cycles = cycles + 1;
        if (cycles == 40000)
        begin
            mismatches = mismatches + 1;
            finish_test;
        end
    end
    initial
    begin
        repeat (4) @(negedge clk_in);
        rst_n_in = 1'b1;
        op_chk(`FCP_OP_READ, 20'h01003, 16'h0000, 16'hffff);
        op_chk(`FCP_OP_PROGRAM, 20'h01003, 16'h1234, 16'h1234);
        op_chk(`FCP_OP_PROGRAM, 20'h15002, 16'h00a5, 16'h00a5);
        op_chk(`FCP_OP_PROGRAM, 20'h05002, 16'h0080, 16'hffff);
        op_chk(`FCP_OP_READ, 20'h15002, 16'h0000, 16'h00a5);
        run_op(`FCP_OP_PROGRAM, 20'h01003, 16'h1235);
        check({15'h0, fail_out}, 16'h0001);
        op_chk(`FCP_OP_READ, 20'h01003, 16'h0000, 16'h1234);
        op_chk(`FCP_OP_AUTOSEL, 20'h05002, 16'h0000, 16'h0001);
        run_op(`FCP_OP_RESET, 20'h00000, 16'h0000);
        op_chk(`FCP_OP_AUTOSEL, 20'h01002, 16'h0000, 16'h0000);
        run_op(`FCP_OP_RESET, 20'h00000, 16'h0000);
        op_chk(`FCP_OP_READ, 20'h01003, 16'h0000, 16'h1234);
        run_op(`FCP_OP_BYPASS, 20'h00000, 16'h0000);
        check({15'h0, bypass_out}, 16'h0001);
        op_chk(`FCP_OP_BYPASS_PROG, 20'h02001, 16'h5a5a, 16'h5a5a);
        run_op(`FCP_OP_BYPASS_RST, 20'h00000, 16'h0000);
        check({15'h0, bypass_out}, 16'h0000);
        run_op(`FCP_OP_SECT_ERASE, 20'h01000, 16'h0000);
        check({15'h0, fail_out}, 16'h0000);
        op_chk(`FCP_OP_READ, 20'h01003, 16'h0000, 16'hffff);
        op_chk(`FCP_OP_READ, 20'h02001, 16'h0000, 16'h5a5a);
        run_op(`FCP_OP_SECT_ERASE, 20'h05000, 16'h0000);
        check({15'h0, fail_out}, 16'h0000);
        run_op(`FCP_OP_SUSPEND, 20'h02000, 16'h0000);
        check({15'h0, suspended_out}, 16'h0001);
        run_op(`FCP_OP_RESUME, 20'h02000, 16'h0000);
        check({15'h0, suspended_out}, 16'h0000);
        run_op(`FCP_OP_CHIP_ERASE, 20'h02001, 16'h0000);
        check({15'h0, fail_out}, 16'h0000);
        op_chk(`FCP_OP_READ, 20'h15002, 16'h0000, 16'hffff);
        finish_test;
    end
endmodule // testbench
